// File: verilog/sero_pkg.sv
// Shared constants and types of the two-wire memory target read logic.
// Assumes a single 100 MHz system clock and a slow external serial clock.
package sero_pkg;

  localparam int ADDR_W = 10;
  localparam int BYTE_W = 8;
  localparam int BLOCK_BYTES = 16;
  localparam int BLOCK_W = BLOCK_BYTES * BYTE_W;

  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_SPECIAL = 4'hb;

  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 1;
  localparam int RW_POS = 0;
  localparam int REGION_MSB = 7;
  localparam int REGION_LSB = 6;
  localparam int BYTE_IN_BLOCK_MSB = 3;

  localparam logic [1:0] REGION_ID = 2'h0;
  localparam logic [1:0] REGION_FREEZE = 2'h1;
  localparam logic [1:0] REGION_SERIAL = 2'h2;
  localparam logic [1:0] REGION_LOCK = 2'h3;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] LOCK_PAD = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;

  typedef enum logic [1:0] {AREA_MAIN, AREA_ID, AREA_SERIAL, AREA_LOCK} sero_area_type;
  typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_MACK} sero_phase_type;
  typedef enum logic [1:0] {RX_DEV, RX_WORD, RX_DATA} sero_rxkind_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } sero_pins_type;

  localparam sero_pins_type PINS_IDLE = '{scl: 1'b1, sda: 1'b1};

  typedef struct packed {
    sero_pins_type stage1;
    sero_pins_type stage2;
  } sero_sync_state_type;

  typedef struct packed {
    logic idLocked;
    logic softWriteLockBit;
    logic progBusy;
  } sero_nv_type;

  typedef struct packed {
    logic active;
    logic reading;
    sero_area_type area;
  } sero_status_type;

  typedef struct packed {
    sero_phase_type phase;
    sero_rxkind_type rxKind;
    logic [3:0] bitCnt;
    logic [BYTE_W-1:0] shift;
    logic [BYTE_W-1:0] devByte;
    logic readDir;
    logic masterAck;
    sero_pins_type prev;
    logic [ADDR_W-1:0] addr;
    sero_area_type area;
    sero_area_type specArea;
    logic sdaOut;
    logic sdaOe;
    sero_status_type status;
  } sero_core_type;

endpackage

// File: verilog/sero_sync.sv
// Two-stage synchroniser for the serial clock and data pins.
// Assumes the pins idle high through their pull-ups.
`timescale 1ns/1ns
module sero_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire sero_pkg::sero_pins_type pinsIn,
  output sero_pkg::sero_pins_type pinsOut
);

  sero_pkg::sero_sync_state_type q;
  sero_pkg::sero_sync_state_type d;

  // The first stage feeds the second stage only.
  always_comb begin
    d = q;
    d.stage1 = pinsIn;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{stage1: sero_pkg::PINS_IDLE, stage2: sero_pkg::PINS_IDLE};
    end else begin
      q <= d;
    end
  end

  assign pinsOut = q.stage2;

endmodule

// File: verilog/sero_read_ops.sv
// Read-side command logic of a two-wire serial memory target.
// Assumes the array, identification and serial blocks are read
// combinationally from storage outside this module on the same clock.
`timescale 1ns/1ns
module sero_read_ops (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire sero_pkg::sero_nv_type nvFlags,
  output logic [sero_pkg::ADDR_W-1:0] memAddr,
  input wire logic [sero_pkg::BYTE_W-1:0] memData,
  input wire logic [sero_pkg::BLOCK_W-1:0] idBlockData,
  input wire logic [sero_pkg::BLOCK_W-1:0] serialBlockData,
  output sero_pkg::sero_status_type status
);

  localparam sero_pkg::sero_core_type CORE_RESET = '{
    phase: sero_pkg::PH_IDLE,
    rxKind: sero_pkg::RX_DEV,
    bitCnt: 4'h0,
    shift: 8'h00,
    devByte: 8'h00,
    readDir: 1'b0,
    masterAck: 1'b0,
    prev: sero_pkg::PINS_IDLE,
    addr: sero_pkg::ADDR_RESET,
    area: sero_pkg::AREA_MAIN,
    specArea: sero_pkg::AREA_ID,
    sdaOut: 1'b0,
    sdaOe: 1'b0,
    status: '{active: 1'b0, reading: 1'b0, area: sero_pkg::AREA_MAIN}
  };

  sero_pkg::sero_core_type q;
  sero_pkg::sero_core_type d;
  sero_pkg::sero_pins_type pinsRaw;
  sero_pkg::sero_pins_type pins;

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic typeOk;
  logic typeArray;
  logic dataAck;
  logic [sero_pkg::BYTE_W-1:0] txByte;
  logic [sero_pkg::BYTE_W-1:0] nextShift;

  // Picks one byte of a 16-byte block; byte zero sits in the low bits.
  function automatic logic [sero_pkg::BYTE_W-1:0] pickByte(
    input logic [sero_pkg::BLOCK_W-1:0] blk,
    input logic [3:0] idx
  );
    pickByte = blk[{idx, 3'h0} +: sero_pkg::BYTE_W];
  endfunction

  // Next counter value after one byte of the given area.
  function automatic logic [sero_pkg::ADDR_W-1:0] incAddr(
    input logic [sero_pkg::ADDR_W-1:0] a,
    input sero_pkg::sero_area_type ar
  );
    unique case (ar)
      sero_pkg::AREA_MAIN: begin
        incAddr = a + 10'h001;
      end
      sero_pkg::AREA_ID, sero_pkg::AREA_SERIAL: begin
        incAddr = {a[sero_pkg::ADDR_W-1:4], a[3:0] + 4'h1};
      end
      sero_pkg::AREA_LOCK: begin
        incAddr = a;
      end
    endcase
  endfunction

  assign pinsRaw = '{scl: sclPin, sda: sdaIn};

  sero_sync u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pinsIn(pinsRaw),
    .pinsOut(pins)
  );

  // Bus events seen by the system clock.
  assign sclRise = pins.scl & ~q.prev.scl;
  assign sclFall = ~pins.scl & q.prev.scl;
  assign startSeen = pins.scl & q.prev.scl & q.prev.sda & ~pins.sda;
  assign stopSeen = pins.scl & q.prev.scl & ~q.prev.sda & pins.sda;

  // The two device type fields that this target answers.
  assign typeArray = q.shift[sero_pkg::TYPE_MSB:sero_pkg::TYPE_LSB] == sero_pkg::TYPE_ARRAY;
  assign typeOk = typeArray
    | (q.shift[sero_pkg::TYPE_MSB:sero_pkg::TYPE_LSB] == sero_pkg::TYPE_SPECIAL);

  // Byte to send, chosen by area and counter; only progBusy blocks a read, by making a Start be ignored, and the lock area byte carries softWriteLockBit.
  always_comb begin
    unique case (q.area)
      sero_pkg::AREA_MAIN: begin
        txByte = memData;
      end
      sero_pkg::AREA_ID: begin
        txByte = pickByte(idBlockData, q.addr[3:0]);
      end
      sero_pkg::AREA_SERIAL: begin
        txByte = pickByte(serialBlockData, q.addr[3:0]);
      end
      sero_pkg::AREA_LOCK: begin
        txByte = {sero_pkg::LOCK_PAD, nvFlags.softWriteLockBit};
      end
    endcase
  end

  // Write data answer: a locked identification block refuses data, and
  // the serial block refuses every write so its content cannot change.
  always_comb begin
    unique case (q.area)
      sero_pkg::AREA_ID: begin
        dataAck = ~nvFlags.idLocked;
      end
      sero_pkg::AREA_SERIAL: begin
        dataAck = 1'b0;
      end
      default: begin
        dataAck = 1'b1;
      end
    endcase
  end

  assign nextShift = {q.shift[sero_pkg::BYTE_W-2:0], pins.sda};

  always_comb begin
    d = q;
    d.prev = pins;
    d.sdaOut = 1'b0;
    if (startSeen) begin
      // A Start drops any pending command, truncated writes included.
      d.sdaOe = 1'b0;
      d.bitCnt = 4'h0;
      d.rxKind = sero_pkg::RX_DEV;
      if (nvFlags.progBusy) begin
        d.phase = sero_pkg::PH_IDLE;
      end else begin
        d.phase = sero_pkg::PH_RX;
      end
    end else if (stopSeen) begin
      d.sdaOe = 1'b0;
      d.phase = sero_pkg::PH_IDLE;
    end else begin
      unique case (q.phase)
        sero_pkg::PH_IDLE: begin
          d.sdaOe = 1'b0;
        end

        sero_pkg::PH_RX: begin
          if (sclRise && (q.bitCnt != sero_pkg::BITS_PER_BYTE)) begin
            d.shift = nextShift;
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && (q.bitCnt == sero_pkg::BITS_PER_BYTE)) begin
            d.bitCnt = 4'h0;
            unique case (q.rxKind)
              sero_pkg::RX_DEV: begin
                if (typeOk) begin
                  d.devByte = q.shift;
                  d.readDir = q.shift[sero_pkg::RW_POS];
                  d.sdaOe = 1'b1;
                  d.phase = sero_pkg::PH_ACK;
                  if (typeArray) begin
                    d.area = sero_pkg::AREA_MAIN;
                  end else begin
                    d.area = q.specArea;
                  end
                end else begin
                  d.phase = sero_pkg::PH_IDLE;
                end
              end

              sero_pkg::RX_WORD: begin
                d.sdaOe = 1'b1;
                d.phase = sero_pkg::PH_ACK;
                if (q.devByte[sero_pkg::TYPE_MSB:sero_pkg::TYPE_LSB] == sero_pkg::TYPE_ARRAY) begin
                  d.addr = {q.devByte[sero_pkg::SEL_MSB:sero_pkg::SEL_LSB], q.shift};
                  d.area = sero_pkg::AREA_MAIN;
                end else begin
                  unique case (q.shift[sero_pkg::REGION_MSB:sero_pkg::REGION_LSB])
                    sero_pkg::REGION_ID, sero_pkg::REGION_FREEZE: begin
                      d.addr = {6'h00, q.shift[sero_pkg::BYTE_IN_BLOCK_MSB:0]};
                      d.area = sero_pkg::AREA_ID;
                      d.specArea = sero_pkg::AREA_ID;
                    end
                    sero_pkg::REGION_SERIAL: begin
                      d.addr = {6'h00, q.shift[sero_pkg::BYTE_IN_BLOCK_MSB:0]};
                      d.area = sero_pkg::AREA_SERIAL;
                      d.specArea = sero_pkg::AREA_SERIAL;
                    end
                    sero_pkg::REGION_LOCK: begin
                      d.area = sero_pkg::AREA_LOCK;
                      d.specArea = sero_pkg::AREA_LOCK;
                    end
                  endcase
                end
              end

              sero_pkg::RX_DATA: begin
                if (dataAck) begin
                  d.sdaOe = 1'b1;
                  d.phase = sero_pkg::PH_ACK;
                  if (q.area == sero_pkg::AREA_MAIN) begin
                    // Written bytes move the counter within their page.
                    d.addr = {q.addr[sero_pkg::ADDR_W-1:4], q.addr[3:0] + 4'h1};
                  end
                end else begin
                  d.phase = sero_pkg::PH_IDLE;
                end
              end

              default: begin
                d.phase = sero_pkg::PH_IDLE;
              end
            endcase
          end
        end

        sero_pkg::PH_ACK: begin
          if (sclFall) begin
            if (q.readDir && (q.rxKind == sero_pkg::RX_DEV)) begin
              // First data bit goes out on the same falling edge.
              d.shift = {txByte[sero_pkg::BYTE_W-2:0], 1'b0};
              d.sdaOe = ~txByte[sero_pkg::BYTE_W-1];
              d.bitCnt = 4'h1;
              d.phase = sero_pkg::PH_TX;
            end else begin
              d.sdaOe = 1'b0;
              d.bitCnt = 4'h0;
              d.phase = sero_pkg::PH_RX;
              if (q.rxKind == sero_pkg::RX_DEV) begin
                d.rxKind = sero_pkg::RX_WORD;
              end else begin
                d.rxKind = sero_pkg::RX_DATA;
              end
            end
          end
        end

        sero_pkg::PH_TX: begin
          if (sclFall) begin
            if (q.bitCnt == sero_pkg::BITS_PER_BYTE) begin
              d.sdaOe = 1'b0;
              d.addr = incAddr(q.addr, q.area);
              d.phase = sero_pkg::PH_MACK;
            end else begin
              d.sdaOe = ~q.shift[sero_pkg::BYTE_W-1];
              d.shift = {q.shift[sero_pkg::BYTE_W-2:0], 1'b0};
              d.bitCnt = q.bitCnt + 4'h1;
            end
          end
        end

        sero_pkg::PH_MACK: begin
          if (sclRise) begin
            d.masterAck = ~pins.sda;
          end else if (sclFall) begin
            if (q.masterAck) begin
              d.shift = {txByte[sero_pkg::BYTE_W-2:0], 1'b0};
              d.sdaOe = ~txByte[sero_pkg::BYTE_W-1];
              d.bitCnt = 4'h1;
              d.phase = sero_pkg::PH_TX;
            end else begin
              d.phase = sero_pkg::PH_IDLE;
            end
          end
        end

        default: begin
          d.sdaOe = 1'b0;
          d.phase = sero_pkg::PH_IDLE;
        end
      endcase
    end
    d.status.active = d.phase != sero_pkg::PH_IDLE;
    d.status.reading = (d.phase == sero_pkg::PH_TX) || (d.phase == sero_pkg::PH_MACK);
    d.status.area = d.area;
  end

  // The counter survives Start and Stop; only the power-on reset clears it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  assign sdaOut = q.sdaOut;
  assign sdaOe = q.sdaOe;
  assign memAddr = q.addr;
  assign status = q.status;

endmodule

// File: test/sero_read_ops_checker.sv
// Concurrent checks on the ports of the read logic.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
module sero_read_ops_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sclPin,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire sero_pkg::sero_nv_type nvFlags,
  input wire logic [sero_pkg::ADDR_W-1:0] memAddr,
  input wire logic [sero_pkg::BYTE_W-1:0] memData,
  input wire logic [sero_pkg::BLOCK_W-1:0] idBlockData,
  input wire logic [sero_pkg::BLOCK_W-1:0] serialBlockData,
  input wire sero_pkg::sero_status_type status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_open_drain:
    assert property (!sdaOut) else $error("data drive value not low");
  chk_oe_scl_low:
    assert property ($changed(sdaOe) |-> !sclPin) else $error("data moved with clock high");
  chk_drive_hold:
    assert property ($rose(sdaOe) |-> sdaOe [*8]) else $error("data low too short");
  chk_idle_quiet:
    assert property (!status.active |-> !sdaOe) else $error("idle device drives data");
  chk_busy_deaf:
    assert property (!status.active && nvFlags.progBusy |=> !status.active)
      else $error("busy device woke up");
  chk_addr_step:
    assert property (status.reading && $past(status.reading)
      && status.area == sero_pkg::AREA_MAIN && $changed(memAddr)
      |-> memAddr == $past(memAddr) + 10'h001) else $error("counter step wrong");
  chk_block_range:
    assert property (status.reading && status.area inside
      {sero_pkg::AREA_ID, sero_pkg::AREA_SERIAL} |-> memAddr[9:4] == 6'h00)
      else $error("block counter out of range");
  chk_lock_steady:
    assert property (status.reading && status.area == sero_pkg::AREA_LOCK
      |-> $stable(memAddr)) else $error("counter moved on lock reads");
endmodule
bind sero_read_ops sero_read_ops_checker chk_u (.sys_clk, .nrst, .sclPin, .sdaIn, .sdaOut,
  .sdaOe, .nvFlags, .memAddr, .memData, .idBlockData, .serialBlockData, .status);

// File: test/sero_master_model.sv
// Two-wire bus master model: drives the serial clock and pulls data low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
module sero_master_model (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic busBit(input logic b, output logic r);
    sdaLow = !b;
    tick(4);
    sclOut = 1'b1;
    tick(4);
    r = sdaWire;
    tick(4);
    sclOut = 1'b0;
    tick(4);
  endtask
  task automatic startCond();
    sdaLow = 1'b0;
    tick(4);
    sclOut = 1'b1;
    tick(4);
    sdaLow = 1'b1;
    tick(4);
    sclOut = 1'b0;
    tick(4);
  endtask
  task automatic stopCond();
    sdaLow = 1'b1;
    tick(4);
    sclOut = 1'b1;
    tick(4);
    sdaLow = 1'b0;
    tick(4);
  endtask
  task automatic wrByte(input logic [7:0] v, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) busBit(v[i], r);
    busBit(1'b1, r);
    acked = !r;
  endtask
  task automatic rdByte(output logic [7:0] v, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      busBit(1'b1, r);
      v[i] = r;
    end
    busBit(!more, r);
  endtask
endmodule

// File: test/sero_read_ops_tb_top.sv
// Self-checking bench for the read logic, driven through the master model.
// Assumes the design package and the master model are compiled first.
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failCount++; \
      $display("BAD %0t got %h want %h", $time, got, exp); \
    end \
  end
module sero_read_ops_tb_top;
  logic sys_clk;
  logic nrst;
  logic sclPin;
  logic sdaLow;
  logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  sero_pkg::sero_nv_type nv;
  logic [9:0] memAddr;
  logic [7:0] memData;
  logic [127:0] idBlk;
  logic [127:0] serBlk;
  sero_pkg::sero_status_type status;
  int failCount;
  int comparisons;
  logic a;
  logic [7:0] d;

  function automatic logic [7:0] memByte(input logic [9:0] ad);
    return ad[7:0] ^ {ad[9:8], 6'h15};
  endfunction
  assign memData = memByte(memAddr);
  assign sdaWire = sdaLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1);

  sero_read_ops dut_u (.sys_clk, .nrst, .sclPin, .sdaIn(sdaWire), .sdaOut, .sdaOe,
    .nvFlags(nv), .memAddr, .memData, .idBlockData(idBlk), .serialBlockData(serBlk), .status);
  sero_master_model mst_u (.sys_clk, .sdaWire, .sclOut(sclPin), .sdaLow);

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wrChk(input logic [7:0] v, input logic exp);
    mst_u.wrByte(v, a);
    `CHK(a, exp)
  endtask
  task automatic rdChk(input logic [7:0] exp, input logic more);
    mst_u.rdByte(d, more);
    `CHK(d, exp)
  endtask
  // Dummy write of the word, then a repeated Start in read direction.
  task automatic setAddr(input logic [7:0] dev, input logic [7:0] word);
    mst_u.startCond();
    wrChk(dev, 1'b1);
    wrChk(word, 1'b1);
    mst_u.startCond();
    wrChk(dev | 8'h01, 1'b1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end
  initial begin
    #500000;
    failCount++;
    wrapUp();
  end
  initial begin
    nrst = 1'b0;
    nv = '0;
    for (int i = 0; i < 16; i++) begin
      idBlk[8*i+:8] = 8'(i) + 8'h10;
      serBlk[8*i+:8] = 8'(i) + 8'h80;
    end
    repeat (6) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    mst_u.tick(4);
    nv.softWriteLockBit = 1'b1;
    setAddr(8'ha6, 8'hfe);
    for (int i = 0; i < 3; i++) rdChk(memByte(10'h3fe + 10'(i)), i < 2);
    mst_u.stopCond();
    `CHK(memAddr, 10'h001)
    mst_u.startCond();
    wrChk(8'ha1, 1'b1);
    rdChk(memByte(10'h001), 1'b0);
    mst_u.stopCond();
    setAddr(8'hb0, 8'h3f);
    rdChk(8'h1f, 1'b1);
    rdChk(8'h10, 1'b0);
    mst_u.stopCond();
    mst_u.startCond();
    wrChk(8'ha1, 1'b1);
    rdChk(memByte(10'h001), 1'b0);
    mst_u.stopCond();
    setAddr(8'hb0, 8'hb0);
    for (int i = 0; i < 17; i++) rdChk(8'(i % 16) + 8'h80, i < 16);
    mst_u.stopCond();
    for (int s = 0; s < 2; s++) begin
      nv.softWriteLockBit = s[0];
      setAddr(8'hb0, 8'hc5);
      rdChk({7'h00, s[0]}, 1'b1);
      rdChk({7'h00, s[0]}, 1'b0);
      mst_u.stopCond();
    end
    for (int k = 0; k < 2; k++) begin
      nv.idLocked = k[0];
      mst_u.startCond();
      wrChk(8'hb0, 1'b1);
      wrChk(8'h05, 1'b1);
      wrChk(8'h5a, !k[0]);
      mst_u.startCond();
      mst_u.stopCond();
      `CHK(status.active, 1'b0)
    end
    setAddr(8'hb0, 8'h43);
    rdChk(8'h13, 1'b0);
    mst_u.stopCond();
    mst_u.startCond();
    wrChk(8'ha0, 1'b1);
    wrChk(8'h1f, 1'b1);
    wrChk(8'h00, 1'b1);
    mst_u.stopCond();
    `CHK(memAddr, 10'h010)
    mst_u.startCond();
    wrChk(8'hb0, 1'b1);
    wrChk(8'h80, 1'b1);
    wrChk(8'h00, 1'b0);
    mst_u.stopCond();
    setAddr(8'hb0, 8'h80);
    rdChk(8'h80, 1'b0);
    mst_u.stopCond();
    nv.progBusy = 1'b1;
    mst_u.startCond();
    wrChk(8'ha1, 1'b0);
    mst_u.stopCond();
    nv.progBusy = 1'b0;
    mst_u.startCond();
    wrChk(8'h51, 1'b0);
    mst_u.stopCond();
    wrapUp();
  end
endmodule
